// >>> csu_host_model.sv
// Host model on the serial status-read port of the status word.
// Assumes the bench drives on falling edges; so does this model.
`timescale 1ns/1ps
module csu_host_model (
    input  wire clk,
    input  wire status_sdo_q,
    output reg  status_read_cmd,
    output reg  shift_en
);
    initial begin
        status_read_cmd = 1'b0;
        shift_en = 1'b0;
    end
    // Host reads the word back only through this slave-side shift port
    task read_word(output [63:0] w);
        integer i;
        begin
            @(negedge clk) status_read_cmd = 1'b1;
            @(negedge clk) status_read_cmd = 1'b0;
            shift_en = 1'b1;
            for (i = 0; i < 64; i = i + 1) begin
                w[i] = status_sdo_q;
                @(negedge clk);
            end
            shift_en = 1'b0;
        end
    endtask
endmodule

// >>> csu_regs.vh
// Constants for the upper configuration status word (bits 18 to 63).
// Assumes inclusion by csu_status_word.v only; definitions, no logic.
`ifndef CSU_REGS_VH
`define CSU_REGS_VH

// ----------------------------------------------------------------
// Word geometry
// ----------------------------------------------------------------
`define CSU_WORD_W        64
`define CSU_CNT_W         7
`define CSU_WORD_LAST     7'h3f
`define CSU_LOW_W         18
`define CSU_RESET_WORD    64'h0000_0000_0000_0000

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CSU_B_CUSTOMER_ID_ENABLED      18
`define CSU_B_ENC_PREAMBLE_ERROR    21
`define CSU_B_STD_PREAMBLE_ERROR    22
`define CSU_B_PRIM_FAIL   23
`define CSU_F_ERR_LO      24
`define CSU_F_ERR_HI      27
`define CSU_B_EXEC_ERR    28
`define CSU_B_ID_ERR      29
`define CSU_B_INV_CMD     30
`define CSU_B_WATCHDOG_BUSY_FLAG    31
`define CSU_B_DRY_DONE    33
`define CSU_F_PERR_LO     34
`define CSU_F_PERR_HI     37
`define CSU_B_BYPASS      38
`define CSU_B_FLOW        39
`define CSU_B_SIG_TMO     42
`define CSU_B_KEY_DESTROY 43
`define CSU_B_INIT_PIN    44
`define CSU_B_PAR_S2      45
`define CSU_B_IBUS_ID     46
`define CSU_B_PAR_S1      47
`define CSU_F_AUTH_LO     48
`define CSU_F_AUTH_HI     49
`define CSU_B_AUTH_DONE   50
`define CSU_B_DRY_AUTH    51
`define CSU_F_PORT_LO     52
`define CSU_F_PORT_HI     54
`define CSU_F_KEY_LO      55
`define CSU_F_KEY_HI      62
`define CSU_B_GLOBAL_LOCK 63

// ----------------------------------------------------------------
// Engine error codes
// ----------------------------------------------------------------
`define CSU_ERR_NONE      4'h0
`define CSU_ERR_MAX       4'ha

`endif

// >>> csu_status_word.v
// Upper configuration status word with its serial status-read shifter.
// Assumes all event and level inputs come from configuration logic on clk,
// except init_status_pin, which is an asynchronous pin.
//
// Behaviour
// - Status-read command shifts out all 64 bits
// - Bit 18 reports customer identifier enabled
// - Bits 21/22 flag encrypted/standard preamble
// - Bit 23 flags primary flash image failure
// - Bits 27:24 hold current engine error
// - Bits 37:34 hold previous bitstream error
// - Bit 28 flags error during command execution
// - Bits 29/30 flag identifier mismatch, invalid command
// - Bit 31 follows watchdog busy
// - Bit 33 flags dry-run pseudo completion
// - Bit 38 follows daisy-chain bypass mode
// - Bit 39 follows daisy-chain flow-through mode
// - Bit 42 flags flash signature read timeout
// - Bit 43 flags key destroy success
// - Bits 45/47 flag S2/S1 parity errors
// - Bit 46 flags initialization bus identifier error
// - Bits 49:48 report authentication mode
// - Bit 50 flags authentication completed
// - Bit 51 flags dry-run authentication completed
// - Bits 52-54 report port locks
// - Bits 55-62 report key read/write locks
// - Bit 63 reports global one-time row lock
`timescale 1ns/1ps
`include "csu_regs.vh"

module csu_status_word (
    input  wire        clk,
    input  wire        rst_n,
    input  wire [17:0] lower_status,
    input  wire        customer_id_enabled,
    input  wire        enc_preamble_det,
    input  wire        std_preamble_det,
    input  wire        primary_image_fail,
    input  wire        err_valid,
    input  wire [3:0]  engine_error_code,
    input  wire        bitstream_start,
    input  wire        exec_error,
    input  wire        id_mismatch,
    input  wire        invalid_cmd,
    input  wire        watchdog_busy_flag,
    input  wire        dry_run_done,
    input  wire        bypass_mode,
    input  wire        flow_through_mode,
    input  wire        sig_timeout,
    input  wire        key_destroy_pass,
    input  wire        parity_err_s2,
    input  wire        init_bus_id_err,
    input  wire        parity_err_s1,
    input  wire [1:0]  auth_mode,
    input  wire        auth_done,
    input  wire        dry_auth_done,
    input  wire [2:0]  port_locks,
    input  wire [7:0]  key_locks,
    input  wire        global_lock,
    input  wire        init_status_pin,
    input  wire        flag_clear,
    input  wire        status_read_cmd,
    input  wire        shift_en,
    output reg  [63:0] status_word_q,
    output reg         status_sdo_q,
    output reg         shift_busy_q
);

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Sticky flag: a set in the clearing cycle wins, so no event is lost
    function sticky;
        input q;
        input set;
        input clr;
        begin
            sticky = set | (q & ~clr);
        end
    endfunction

    // ----------------------------------------------------------------
    // Pin synchroniser
    // ----------------------------------------------------------------
    reg        init_meta_q;
    reg        init_sync_q;

    always @(posedge clk) begin
        if (!rst_n) begin
            init_meta_q <= 1'b0;
            init_sync_q <= 1'b0;
        end else begin
            init_meta_q <= init_status_pin;
            init_sync_q <= init_meta_q;
        end
    end

    // ----------------------------------------------------------------
    // Sticky event flags
    // ----------------------------------------------------------------
    reg        enc_preamble_error_q;
    reg        std_preamble_error_q;
    reg        prim_fail_q;
    reg        exec_err_q;
    reg        id_err_q;
    reg        inv_cmd_q;
    reg        dry_done_q;
    reg        sig_tmo_q;
    reg        key_destroy_q;
    reg        par_s2_q;
    reg        ibus_id_q;
    reg        par_s1_q;
    reg        auth_done_q;
    reg        dry_auth_q;
    reg        enc_preamble_error_d;
    reg        std_preamble_error_d;
    reg        prim_fail_d;
    reg        exec_err_d;
    reg        id_err_d;
    reg        inv_cmd_d;
    reg        dry_done_d;
    reg        sig_tmo_d;
    reg        key_destroy_d;
    reg        par_s2_d;
    reg        ibus_id_d;
    reg        par_s1_d;
    reg        auth_done_d;
    reg        dry_auth_d;

    always @* begin
        enc_preamble_error_d    = sticky(enc_preamble_error_q, enc_preamble_det, flag_clear);
        std_preamble_error_d    = sticky(std_preamble_error_q, std_preamble_det, flag_clear);
        prim_fail_d   = sticky(prim_fail_q, primary_image_fail, flag_clear);
        exec_err_d    = sticky(exec_err_q, exec_error, flag_clear);
        id_err_d      = sticky(id_err_q, id_mismatch, flag_clear);
        inv_cmd_d     = sticky(inv_cmd_q, invalid_cmd, flag_clear);
        dry_done_d    = sticky(dry_done_q, dry_run_done, flag_clear);
        sig_tmo_d     = sticky(sig_tmo_q, sig_timeout, flag_clear);
        key_destroy_d = sticky(key_destroy_q, key_destroy_pass, flag_clear);
        par_s2_d      = sticky(par_s2_q, parity_err_s2, flag_clear);
        ibus_id_d     = sticky(ibus_id_q, init_bus_id_err, flag_clear);
        par_s1_d      = sticky(par_s1_q, parity_err_s1, flag_clear);
        auth_done_d   = sticky(auth_done_q, auth_done, flag_clear);
        dry_auth_d    = sticky(dry_auth_q, dry_auth_done, flag_clear);
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            enc_preamble_error_q    <= 1'b0;
            std_preamble_error_q    <= 1'b0;
            prim_fail_q   <= 1'b0;
            exec_err_q    <= 1'b0;
            id_err_q      <= 1'b0;
            inv_cmd_q     <= 1'b0;
            dry_done_q    <= 1'b0;
            sig_tmo_q     <= 1'b0;
            key_destroy_q <= 1'b0;
            par_s2_q      <= 1'b0;
            ibus_id_q     <= 1'b0;
            par_s1_q      <= 1'b0;
            auth_done_q   <= 1'b0;
            dry_auth_q    <= 1'b0;
        end else begin
            enc_preamble_error_q    <= enc_preamble_error_d;
            std_preamble_error_q    <= std_preamble_error_d;
            prim_fail_q   <= prim_fail_d;
            exec_err_q    <= exec_err_d;
            id_err_q      <= id_err_d;
            inv_cmd_q     <= inv_cmd_d;
            dry_done_q    <= dry_done_d;
            sig_tmo_q     <= sig_tmo_d;
            key_destroy_q <= key_destroy_d;
            par_s2_q      <= par_s2_d;
            ibus_id_q     <= ibus_id_d;
            par_s1_q      <= par_s1_d;
            auth_done_q   <= auth_done_d;
            dry_auth_q    <= dry_auth_d;
        end
    end

    // ----------------------------------------------------------------
    // Engine error codes
    // ----------------------------------------------------------------
    // A new bitstream retires the current code into the previous field;
    // a code reported in that same cycle belongs to the new bitstream.
    reg  [3:0] err_cur_q;
    reg  [3:0] err_prev_q;
    reg  [3:0] err_cur_d;
    reg  [3:0] err_prev_d;

    always @* begin
        err_cur_d  = err_cur_q;
        err_prev_d = err_prev_q;
        if (bitstream_start) begin
            err_prev_d = err_cur_q;
            err_cur_d  = `CSU_ERR_NONE;
        end
        // Codes above the last defined one are not stored
        if (err_valid && (engine_error_code <= `CSU_ERR_MAX)) begin
            err_cur_d = engine_error_code;
        end
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            err_cur_q  <= `CSU_ERR_NONE;
            err_prev_q <= `CSU_ERR_NONE;
        end else begin
            err_cur_q  <= err_cur_d;
            err_prev_q <= err_prev_d;
        end
    end

    // ----------------------------------------------------------------
    // Word assembly
    // ----------------------------------------------------------------
    reg  [63:0] word_d;

    always @* begin
        word_d = `CSU_RESET_WORD;
        word_d[`CSU_LOW_W-1:0]                    = lower_status;
        word_d[`CSU_B_CUSTOMER_ID_ENABLED]                     = customer_id_enabled;
        word_d[`CSU_B_ENC_PREAMBLE_ERROR]                   = enc_preamble_error_q;
        word_d[`CSU_B_STD_PREAMBLE_ERROR]                   = std_preamble_error_q;
        word_d[`CSU_B_PRIM_FAIL]                  = prim_fail_q;
        word_d[`CSU_F_ERR_HI:`CSU_F_ERR_LO]       = err_cur_q;
        word_d[`CSU_B_EXEC_ERR]                   = exec_err_q;
        word_d[`CSU_B_ID_ERR]                     = id_err_q;
        word_d[`CSU_B_INV_CMD]                    = inv_cmd_q;
        word_d[`CSU_B_WATCHDOG_BUSY_FLAG]                   = watchdog_busy_flag;
        word_d[`CSU_B_DRY_DONE]                   = dry_done_q;
        word_d[`CSU_F_PERR_HI:`CSU_F_PERR_LO]     = err_prev_q;
        word_d[`CSU_B_BYPASS]                     = bypass_mode;
        word_d[`CSU_B_FLOW]                       = flow_through_mode;
        word_d[`CSU_B_SIG_TMO]                    = sig_tmo_q;
        word_d[`CSU_B_KEY_DESTROY]                = key_destroy_q;
        word_d[`CSU_B_INIT_PIN]                   = init_sync_q;
        word_d[`CSU_B_PAR_S2]                     = par_s2_q;
        word_d[`CSU_B_IBUS_ID]                    = ibus_id_q;
        word_d[`CSU_B_PAR_S1]                     = par_s1_q;
        // Both 00 and 11 mean no authentication; the raw code is shown
        word_d[`CSU_F_AUTH_HI:`CSU_F_AUTH_LO]     = auth_mode;
        word_d[`CSU_B_AUTH_DONE]                  = auth_done_q;
        word_d[`CSU_B_DRY_AUTH]                   = dry_auth_q;
        word_d[`CSU_F_PORT_HI:`CSU_F_PORT_LO]     = port_locks;
        word_d[`CSU_F_KEY_HI:`CSU_F_KEY_LO]       = key_locks;
        word_d[`CSU_B_GLOBAL_LOCK]                = global_lock;
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            status_word_q <= `CSU_RESET_WORD;
        end else begin
            status_word_q <= word_d;
        end
    end

    // ----------------------------------------------------------------
    // Status-read shifter
    // ----------------------------------------------------------------
    // The word is captured whole at the command so the host sees one
    // coherent snapshot even while flags keep changing during the shift.
    // Only a slave-port command path drives status_read_cmd.
    reg  [63:0] shift_q;
    reg  [6:0]  bit_cnt_q;
    reg  [63:0] shift_d;
    reg  [6:0]  bit_cnt_d;
    reg         shift_busy_d;
    reg         status_sdo_d;

    always @* begin
        shift_d      = shift_q;
        bit_cnt_d    = bit_cnt_q;
        shift_busy_d = shift_busy_q;
        status_sdo_d = status_sdo_q;
        if (status_read_cmd) begin
            shift_d      = status_word_q;
            bit_cnt_d    = 7'h00;
            shift_busy_d = 1'b1;
            status_sdo_d = status_word_q[0];
        end else if (shift_busy_q && shift_en) begin
            shift_d      = {1'b0, shift_q[63:1]};
            status_sdo_d = shift_q[1];
            bit_cnt_d    = bit_cnt_q + 7'h01;
            // The last bit leaves the line low so an idle port reads zero
            if (bit_cnt_q == `CSU_WORD_LAST) begin
                shift_busy_d = 1'b0;
                status_sdo_d = 1'b0;
            end
        end
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            shift_q      <= `CSU_RESET_WORD;
            bit_cnt_q    <= 7'h00;
            shift_busy_q <= 1'b0;
            status_sdo_q <= 1'b0;
        end else begin
            shift_q      <= shift_d;
            bit_cnt_q    <= bit_cnt_d;
            shift_busy_q <= shift_busy_d;
            status_sdo_q <= status_sdo_d;
        end
    end

endmodule

// >>> csu_status_word_chk.sv
// Concurrent checks on the upper status word and its serial read-out.
// Assumes a bind onto csu_status_word; sees only that module's ports.
`timescale 1ns/1ps
module csu_status_word_chk (
    input wire        clk,
    input wire        rst_n,
    input wire        customer_id_enabled,
    input wire        watchdog_busy_flag,
    input wire        bypass_mode,
    input wire        flow_through_mode,
    input wire [1:0]  auth_mode,
    input wire [2:0]  port_locks,
    input wire [7:0]  key_locks,
    input wire        global_lock,
    input wire        enc_preamble_det,
    input wire        invalid_cmd,
    input wire        key_destroy_pass,
    input wire        flag_clear,
    input wire        err_valid,
    input wire [3:0]  engine_error_code,
    input wire        bitstream_start,
    input wire        status_read_cmd,
    input wire        shift_en,
    input wire [63:0] status_word_q,
    input wire        status_sdo_q,
    input wire        shift_busy_q
);
    // Counts shifted bits; 64 is too long for a repetition
    reg  [6:0] cnt_q;
    wire [2:0] stk = {status_word_q[43], status_word_q[30], status_word_q[21]};
    wire [2:0] ev  = {key_destroy_pass, invalid_cmd, enc_preamble_det};
    always @(posedge clk) begin
        if (!rst_n || status_read_cmd)
            cnt_q <= 7'h00;
        else if (shift_busy_q && shift_en)
            cnt_q <= cnt_q + 7'h01;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_reserved_zero: assert property (
        {status_word_q[41:40], status_word_q[32], status_word_q[20:19]} == 5'h00)
        else $error("reserved bit set");
    a_mode_follow: assert property ($past(rst_n) |->
        {status_word_q[49:48], status_word_q[39:38], status_word_q[31], status_word_q[18]}
        == $past({auth_mode, flow_through_mode, bypass_mode, watchdog_busy_flag,
        customer_id_enabled})) else $error("mode bits wrong");
    a_lock_follow: assert property ($past(rst_n) |->
        status_word_q[63:52] == $past({global_lock, key_locks, port_locks}))
        else $error("lock bits wrong");
    a_sticky_set: assert property (|ev |->
        ##2 (stk & $past(ev, 2)) == $past(ev, 2)) else $error("event flag not set");
    a_sticky_hold: assert property ($past(rst_n) && |($past(stk) & ~stk) |->
        $past(flag_clear) || $past(flag_clear, 2)) else $error("flag dropped");
    a_err_range: assert property (
        status_word_q[27:24] <= 4'ha) else $error("error code out of range");
    a_err_load: assert property (err_valid && engine_error_code <= 4'ha &&
        !bitstream_start ##1 !err_valid && !bitstream_start |->
        ##1 status_word_q[27:24] == $past(engine_error_code, 2)) else $error("code not loaded");
    a_prev_move: assert property (bitstream_start && !err_valid |-> ##2
        status_word_q[27:24] == 4'h0 && status_word_q[37:34] == $past(status_word_q[27:24]))
        else $error("previous code wrong");
    a_shift_start: assert property (status_read_cmd |=> shift_busy_q &&
        status_sdo_q == $past(status_word_q[0])) else $error("first bit wrong");
    a_shift_len: assert property ($past(rst_n) && $fell(shift_busy_q) |->
        cnt_q == 7'h40) else $error("shift length wrong");
endmodule
bind csu_status_word csu_status_word_chk chk_i (.*);

// >>> csu_status_word_tb.sv
// Self-checking bench for the upper configuration status word.
// Assumes csu_status_word, its bound checker and csu_host_model.
`timescale 1ns/1ps
module csu_status_word_tb;
    localparam [111:0] POS = {8'h33, 8'h32, 8'h2f, 8'h2e, 8'h2d, 8'h2b, 8'h2a,
                              8'h21, 8'h1e, 8'h1d, 8'h1c, 8'h17, 8'h16, 8'h15};
    reg         clk;
    reg         rst_n;
    reg  [36:0] lv;
    reg  [13:0] ev;
    reg         err_valid;
    reg  [3:0]  code;
    reg         bs_start;
    reg         clr;
    reg  [63:0] stk;
    reg  [63:0] rd;
    reg  [3:0]  cur;
    reg  [3:0]  prv;
    wire        rd_cmd;
    wire        sh_en;
    wire        sdo;
    wire        busy;
    wire [63:0] word;
    integer     mismatches;
    integer     comparisons;
    integer     i;
    // Expected word from what the bench drove, not from the design
    wire [63:0] exp_w = stk | {lv[36:25], 2'h0, lv[24:23], 3'h0, lv[22], 4'h0, lv[21:20],
                               prv, 2'h0, lv[19], 3'h0, cur, 5'h00, lv[18:0]};
    csu_status_word dut (
        .clk(clk), .rst_n(rst_n), .lower_status(lv[17:0]), .customer_id_enabled(lv[18]),
        .enc_preamble_det(ev[0]), .std_preamble_det(ev[1]), .primary_image_fail(ev[2]),
        .err_valid(err_valid), .engine_error_code(code), .bitstream_start(bs_start),
        .exec_error(ev[3]), .id_mismatch(ev[4]), .invalid_cmd(ev[5]),
        .watchdog_busy_flag(lv[19]), .dry_run_done(ev[6]), .bypass_mode(lv[20]),
        .flow_through_mode(lv[21]), .sig_timeout(ev[7]), .key_destroy_pass(ev[8]),
        .parity_err_s2(ev[9]), .init_bus_id_err(ev[10]), .parity_err_s1(ev[11]),
        .auth_mode(lv[24:23]), .auth_done(ev[12]), .dry_auth_done(ev[13]),
        .port_locks(lv[27:25]), .key_locks(lv[35:28]), .global_lock(lv[36]),
        .init_status_pin(lv[22]), .flag_clear(clr), .status_read_cmd(rd_cmd),
        .shift_en(sh_en), .status_word_q(word), .status_sdo_q(sdo), .shift_busy_q(busy));
    csu_host_model host (.clk(clk), .status_sdo_q(sdo), .status_read_cmd(rd_cmd),
                         .shift_en(sh_en));
    task chk(input [47:0] nm, input [63:0] e, input [63:0] g);
        begin
            comparisons = comparisons + 1;
            if (g !== e) begin
                mismatches = mismatches + 1;
                $display("ERROR %0s expected %h seen %h", nm, e, g);
            end
        end
    endtask
    task cyc(input integer n);
        repeat (n) @(negedge clk);
    endtask
    task tally_and_finish;
        begin
            $display("comparisons %0d mismatches %0d", comparisons, mismatches);
            if (mismatches == 0 && comparisons > 0)
                $display("bench passed");
            else
                $display("bench failed");
            $finish;
        end
    endtask
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Whole run is a few hundred cycles; allow a wide margin
    initial begin
        #(50 * 3000);
        mismatches = mismatches + 1;
        tally_and_finish;
    end
    initial begin
        {rst_n, lv, ev, err_valid, code, bs_start, clr, stk, cur, prv} = 0;
        {mismatches, comparisons} = 0;
        cyc(20);
        rst_n = 1'b1;
        cyc(2);
        chk("word", exp_w, word);
        host.read_word(rd);
        chk("serial", exp_w, rd);
        chk("busy", 64'h0, {63'h0, busy});
        $display("test 1 done");
        for (i = 0; i < 4; i = i + 1) begin
            lv = {i[0] ? 12'ha5a : 12'h5a5, i[1:0], i[0] ? 23'h5a5a5a : 23'h25a5a5};
            cyc(4);
            chk("word", exp_w, word);
        end
        $display("test 2 done");
        for (i = 0; i < 14; i = i + 1) begin
            ev = 14'h0001 << i;
            cyc(1);
            ev = 14'h0000;
            stk[POS[8*i +: 8]] = 1'b1;
            cyc(2);
            chk("word", exp_w, word);
        end
        clr = 1'b1;
        cyc(1);
        clr = 1'b0;
        stk = 64'h0;
        cyc(3);
        chk("word", exp_w, word);
        ev = 14'h3fff;
        cyc(1);
        {ev, rst_n} = 15'h0000;
        cyc(2);
        chk("reset", 64'h0, word);
        rst_n = 1'b1;
        cyc(4);
        chk("word", exp_w, word);
        $display("test 3 done");
        for (i = 0; i < 16; i = i + 1) begin
            {err_valid, code} = {1'b1, i[3:0]};
            cyc(1);
            err_valid = 1'b0;
            if (i < 11)
                cur = i[3:0];
            cyc(2);
            chk("word", exp_w, word);
        end
        bs_start = 1'b1;
        cyc(1);
        {bs_start, prv, cur} = {1'b0, cur, 4'h0};
        cyc(2);
        chk("word", exp_w, word);
        {err_valid, code, bs_start} = {1'b1, 4'h7, 1'b1};
        cyc(1);
        {err_valid, bs_start, prv, cur} = {2'b00, cur, 4'h7};
        cyc(2);
        chk("word", exp_w, word);
        host.read_word(rd);
        chk("serial", exp_w, rd);
        chk("busy", 64'h0, {63'h0, busy});
        $display("test 4 done");
        tally_and_finish;
    end
endmodule
